/* File: inc/pulse_timer_pkg.sv */
package pulse_timer_pkg;
    // ******
    // Clock and timing
    // ******
    localparam int unsigned CLK_HZ = 40_000_000;
    // Emergency pin figures in periods of the timer clock.
    localparam int unsigned EMG_MIN_LOW_FC = 4;
    localparam int unsigned EMG_RESP_FC = 10;
    // Two clean low samples fit well inside the shortest legal pulse.
    localparam int unsigned EMG_FILT_CYC = EMG_MIN_LOW_FC / 2;
    // ******
    // Register map (byte addresses)
    // ******
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_DEAD = 8'h10;
    localparam logic [7:0] OFS_COUNT = 8'h14;
    // control_reg_one fields.
    localparam int unsigned B_OUT1_INIT = 0;
    localparam int unsigned B_OUT2_INIT = 1;
    localparam int unsigned B_EDGE_LO = 2;
    localparam int unsigned B_CAPTURE = 4;
    // control_reg_two fields.
    localparam int unsigned B_EMG_EN = 0;
    localparam int unsigned B_EMG_REL = 7;
    // control_reg_three fields.
    localparam int unsigned B_RUN = 0;
    localparam int unsigned B_STM_LO = 1;
    localparam int unsigned B_EMG_FLAG = 4;
    localparam int unsigned B_BUSY = 5;
    // ******
    // Codes
    // ******
    localparam logic [1:0] EDGE_COMMAND = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] STM_INIT = 2'h0;
    localparam logic [1:0] STM_HOLD = 2'h1;
    localparam logic [1:0] STM_END = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] DEAD_RST = 16'h0000;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN, ST_DONE} cnt_state_type;
endpackage : pulse_timer_pkg

/* File: src/emg_filter.sv */
`timescale 1ns/1ps
module emg_filter
    import pulse_timer_pkg::*;
#(
    parameter int unsigned SAMPLES = EMG_FILT_CYC
) (
    input wire logic ref_clk_i, // Timer clock
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire logic pin_n_i, // Emergency pin, active low
    input wire logic enable_i, // Pin accepted when high
    output logic low_o // Filtered accepted low level
);
    logic [SAMPLES-1:0] smp_q;

    // A low must stand for every sample so a glitch cannot stop the outputs.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            smp_q <= '1;
            low_o <= 1'b0;
        end else begin
            smp_q <= {smp_q[SAMPLES-2:0], pin_n_i};
            low_o <= enable_i && (smp_q == '0);
        end
    end
endmodule : emg_filter

/* File: src/edge_detect.sv */
`timescale 1ns/1ps
module edge_detect (
    input wire logic ref_clk_i, // Timer clock
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire logic sig_i, // Sampled trigger level
    output logic level_o, // Registered level
    output logic rise_o, // Rising edge pulse
    output logic fall_o // Falling edge pulse
);
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            // Start at the pin's level: no false edge.
            level_o <= sig_i;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            level_o <= sig_i;
            rise_o <= sig_i && !level_o;
            fall_o <= !sig_i && level_o;
        end
    end
endmodule : edge_detect

/* File: src/pulse_timer_unit.sv */
// Operation
// - Trigger-start event when chosen edge starts count
// - No trigger event for count-clearing edge
// - Capture mode edges never give trigger event
// - Trigger event still raised during emergency stop
// - Period event on command start and period end
// - Period match event also during emergency stop
// - Command start at stop level waits for edge
// - Enable bit accepts or ignores emergency pin
// - Emergency low forces initial levels, raises event
// - Emergency leaves the counter running
// - Emergency enable resets to zero
// - Emergency pin sampled on timer clock
// - Emergency flag reads one while outputs forced
// - Release works only when stopped, mode zero
// - Release while pin low re-enters, new event
// - Every accepted emergency input raises event
// - Restart refused while emergency state holds
// - Outputs initialised within ten clocks of low
// - Low-power mode entry initialises, halts timer
// - Initial-level bit sets idle level and polarity
// - Run cleared with mode zero stops, initialises
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module pulse_timer_unit
    import pulse_timer_pkg::*;
#(
    parameter int unsigned CNT_W = 16
) (
    input wire logic ref_clk_i, // Timer clock
    input wire logic reset_n_i, // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte enables
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic trigger_pin_i, // Trigger input level
    input wire logic emergency_stop_pin_n_i, // Emergency input, active low
    input wire logic low_power_mode_i, // High in stop, slow or sleep mode
    output logic wave_out_one_o, // Waveform output one
    output logic wave_out_two_o, // Waveform output two
    output logic trigger_start_irq_o, // Trigger-start request pulse
    output logic period_irq_o, // Period request pulse
    output logic emergency_stop_irq_o // Emergency-stop request pulse
);
    // ******
    // Declarations
    // ******
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_full_q;
    logic w_full_q;
    logic wr_do;
    logic out1_init_q;
    logic out2_init_q;
    logic [1:0] start_edge_q;
    logic capture_q;
    logic emg_en_q;
    logic run_q;
    logic [1:0] stm_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] dead_q;
    logic [CNT_W-1:0] cnt_q;
    cnt_state_type state_q;
    logic flag_q;
    logic emg_low;
    logic emg_low_q;
    logic accept;
    logic release_ok;
    logic trig_lvl;
    logic trig_rise;
    logic trig_fall;
    logic start_edge;
    logic stop_level;
    logic period_end;
    logic init_now;

    // ******
    // Helpers
    // ******
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFS_CTRL_ONE) || (a == OFS_CTRL_TWO) ||
            (a == OFS_CTRL_THREE) || (a == OFS_PERIOD) ||
            (a == OFS_DEAD) || (a == OFS_COUNT);
    endfunction : is_mapped

    function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old_v,
        input logic [31:0] new_v, input logic [3:0] strb);
        logic [CNT_W-1:0] r;
        r = old_v;
        for (int i = 0; i < CNT_W / 8; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
        wr_hit = wr_do && (awaddr_q == ofs);
    endfunction : wr_hit

    // ******
    // AXI4-Lite slave
    // ******
    assign wr_do = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_full_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_full_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= '0;
            unique case (s_axi_araddr)
                OFS_CTRL_ONE: begin
                    s_axi_rdata[B_OUT1_INIT] <= out1_init_q;
                    s_axi_rdata[B_OUT2_INIT] <= out2_init_q;
                    s_axi_rdata[B_EDGE_LO +: 2] <= start_edge_q;
                    s_axi_rdata[B_CAPTURE] <= capture_q;
                end
                OFS_CTRL_TWO: s_axi_rdata[B_EMG_EN] <= emg_en_q;
                OFS_CTRL_THREE: begin
                    s_axi_rdata[B_RUN] <= run_q;
                    s_axi_rdata[B_STM_LO +: 2] <= stm_q;
                    s_axi_rdata[B_EMG_FLAG] <= flag_q;
                    s_axi_rdata[B_BUSY] <= (state_q == ST_RUN);
                end
                OFS_PERIOD: s_axi_rdata[CNT_W-1:0] <= period_q;
                OFS_DEAD: s_axi_rdata[CNT_W-1:0] <= dead_q;
                OFS_COUNT: s_axi_rdata[CNT_W-1:0] <= cnt_q;
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ******
    // Control registers
    // ******
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            out1_init_q <= 1'b0;
            out2_init_q <= 1'b0;
            start_edge_q <= EDGE_COMMAND;
            capture_q <= 1'b0;
            emg_en_q <= 1'b0;
            period_q <= PERIOD_RST[CNT_W-1:0];
            dead_q <= DEAD_RST[CNT_W-1:0];
        end else begin
            if (wr_hit(OFS_CTRL_ONE) && wstrb_q[0]) begin
                out1_init_q <= wdata_q[B_OUT1_INIT];
                out2_init_q <= wdata_q[B_OUT2_INIT];
                start_edge_q <= wdata_q[B_EDGE_LO +: 2];
                capture_q <= wdata_q[B_CAPTURE];
            end
            if (wr_hit(OFS_CTRL_TWO) && wstrb_q[0]) begin
                emg_en_q <= wdata_q[B_EMG_EN];
            end
            if (wr_hit(OFS_PERIOD)) begin
                period_q <= merge(period_q, wdata_q, wstrb_q);
            end
            if (wr_hit(OFS_DEAD)) begin
                dead_q <= merge(dead_q, wdata_q, wstrb_q);
            end
        end
    end

    // Run bit: power mode entry clears it; the emergency state only refuses a write that sets it.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            run_q <= 1'b0;
            stm_q <= STM_INIT;
        end else if (low_power_mode_i) begin
            run_q <= 1'b0;
            stm_q <= STM_INIT;
        end else if (wr_hit(OFS_CTRL_THREE) && wstrb_q[0]) begin
            run_q <= wdata_q[B_RUN] && !flag_q;
            stm_q <= wdata_q[B_STM_LO +: 2];
        end
    end

    // ******
    // Emergency stop
    // ******
    emg_filter u_emg_filter (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .pin_n_i(emergency_stop_pin_n_i),
        .enable_i(emg_en_q),
        .low_o(emg_low)
    );

    assign release_ok = wr_do && (awaddr_q == OFS_CTRL_TWO) && wstrb_q[0] &&
        wdata_q[B_EMG_REL] && !run_q && (stm_q == STM_INIT);
    // A fresh low, or a release while still low, is a new acceptance.
    assign accept = emg_low && (!emg_low_q || release_ok);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            emg_low_q <= 1'b0;
            flag_q <= 1'b0;
            emergency_stop_irq_o <= 1'b0;
        end else begin
            emg_low_q <= emg_low;
            emergency_stop_irq_o <= accept;
            if (accept) begin
                flag_q <= 1'b1;
            end else if (release_ok) begin
                flag_q <= 1'b0;
            end
        end
    end

    // ******
    // Counter
    // ******
    edge_detect u_edge_detect (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .sig_i(trigger_pin_i),
        .level_o(trig_lvl),
        .rise_o(trig_rise),
        .fall_o(trig_fall)
    );

    assign start_edge = (start_edge_q == EDGE_RISE) ? trig_rise :
        (start_edge_q == EDGE_FALL) ? trig_fall : 1'b0;
    assign stop_level = (start_edge_q == EDGE_RISE) ? !trig_lvl : trig_lvl;
    assign period_end = (state_q == ST_RUN) && (cnt_q == period_q);
    assign init_now = low_power_mode_i ||
        (!run_q && (stm_q == STM_INIT) && (state_q != ST_IDLE));

    // The emergency state does not appear here: the count keeps going.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            period_irq_o <= 1'b0;
            trigger_start_irq_o <= 1'b0;
        end else begin
            period_irq_o <= 1'b0;
            trigger_start_irq_o <= 1'b0;
            if (init_now) begin
                state_q <= ST_IDLE;
                cnt_q <= '0;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (run_q && !capture_q && (start_edge_q != EDGE_COMMAND) &&
                            stop_level) begin
                            state_q <= ST_WAIT;
                        end else if (run_q) begin
                            state_q <= ST_RUN;
                            cnt_q <= '0;
                            period_irq_o <= 1'b1;
                        end
                    end
                    ST_WAIT: begin
                        if (!run_q) begin
                            state_q <= ST_IDLE;
                        end else if (start_edge) begin
                            state_q <= ST_RUN;
                            cnt_q <= '0;
                            trigger_start_irq_o <= 1'b1;
                        end
                    end
                    ST_RUN: begin
                        if (!run_q && (stm_q == STM_HOLD)) begin
                            state_q <= ST_IDLE;
                        end else if (period_end) begin
                            cnt_q <= '0;
                            period_irq_o <= 1'b1;
                            if (!run_q) begin
                                state_q <= ST_IDLE;
                            end else if (stm_q == STM_END) begin
                                state_q <= (start_edge_q == EDGE_COMMAND || capture_q) ?
                                    ST_DONE : ST_WAIT;
                            end
                        end else if (capture_q && start_edge) begin
                            cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    ST_DONE: begin
                        if (!run_q) begin
                            state_q <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // ******
    // Waveform outputs
    // ******
    // Output follows its initial level until the dead-time match, then inverts.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            wave_out_one_o <= 1'b0;
            wave_out_two_o <= 1'b0;
        end else if (accept || flag_q || init_now) begin
            wave_out_one_o <= out1_init_q;
            wave_out_two_o <= out2_init_q;
        end else if (state_q == ST_RUN) begin
            if (period_end) begin
                wave_out_one_o <= out1_init_q;
                wave_out_two_o <= out2_init_q;
            end else if (cnt_q == dead_q) begin
                wave_out_one_o <= !out1_init_q;
                wave_out_two_o <= !out2_init_q;
            end
        end else if (state_q != ST_IDLE || run_q) begin
            wave_out_one_o <= out1_init_q;
            wave_out_two_o <= out2_init_q;
        end
    end
endmodule : pulse_timer_unit

/* File: bench/pulse_timer_chk.sv */
`timescale 1ns/1ps
module pulse_timer_chk
    import pulse_timer_pkg::*;
(
    input wire logic ref_clk_i, // clk
    input wire logic reset_n_i, // reset
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic trigger_pin_i, // trigger
    input wire logic emergency_stop_pin_n_i, // emergency
    input wire logic low_power_mode_i, // low power
    input wire logic wave_out_one_o, // wave one
    input wire logic wave_out_two_o, // wave two
    input wire logic trigger_start_irq_o, // trigger irq
    input wire logic period_irq_o, // period irq
    input wire logic emergency_stop_irq_o // emergency irq
);
    // ******
    // Shadow of the control bits
    // ******
    // The shadow lags the design a cycle; each use leans the safe way.
    logic [7:0] wa_q;
    logic [7:0] wd_q;
    logic en_q;
    logic cap_q;
    logic [1:0] ini_q;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            {wa_q, wd_q, en_q, cap_q, ini_q} <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
            if (s_axi_bvalid && s_axi_bready && wa_q == OFS_CTRL_TWO) en_q <= wd_q[B_EMG_EN];
            if (s_axi_bvalid && s_axi_bready && wa_q == OFS_CTRL_ONE) begin
                cap_q <= wd_q[B_CAPTURE];
                ini_q <= wd_q[1:0];
            end
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_trig_pulse; trigger_start_irq_o |=> !trigger_start_irq_o; endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger irq too long");
    property p_per_pulse; period_irq_o |=> !period_irq_o; endproperty
    a_per_pulse: assert property (p_per_pulse) else $error("period irq too long");
    property p_emg_pulse; emergency_stop_irq_o |=> !emergency_stop_irq_o; endproperty
    a_emg_pulse: assert property (p_emg_pulse) else $error("emergency irq too long");
    property p_emg_resp; (en_q && !emergency_stop_pin_n_i) [*4] |-> ##[0:7]
        (wave_out_one_o == ini_q[0] && wave_out_two_o == ini_q[1]); endproperty
    a_emg_resp: assert property (p_emg_resp) else $error("outputs not forced");
    property p_irq_en; emergency_stop_irq_o |-> en_q; endproperty
    a_irq_en: assert property (p_irq_en) else $error("emergency irq while disabled");
    property p_capture; cap_q |-> !trigger_start_irq_o; endproperty
    a_capture: assert property (p_capture) else $error("trigger irq in capture");
    property p_trig_edge;
        trigger_start_irq_o |-> $past(trigger_pin_i, 1) != $past(trigger_pin_i, 5); endproperty
    a_trig_edge: assert property (p_trig_edge) else $error("trigger irq without edge");
    property p_lowpow; low_power_mode_i [*3] |-> !period_irq_o && !trigger_start_irq_o
        && wave_out_one_o == ini_q[0] && wave_out_two_o == ini_q[1]; endproperty
    a_lowpow: assert property (p_lowpow) else $error("timer active in low power");
endmodule : pulse_timer_chk
bind pulse_timer_unit pulse_timer_chk u_chk (.*);

/* File: bench/pin_source.sv */
`timescale 1ns/1ps
module pin_source
    import pulse_timer_pkg::*;
(
    input wire logic ref_clk_i, // clk
    output logic trigger_pin_o, // trigger level
    output logic emergency_stop_pin_n_o // emergency, active low
);
    // Shared pin in input mode: always a driven level.
    initial begin
        trigger_pin_o = 1'h0;
        emergency_stop_pin_n_o = 1'h1;
    end
    task automatic set_trig(input logic v);
        @(posedge ref_clk_i);
        trigger_pin_o <= v;
        repeat (8) @(posedge ref_clk_i);
    endtask : set_trig
    // Lows are held past the minimum width.
    task automatic set_emg(input logic v);
        @(posedge ref_clk_i);
        emergency_stop_pin_n_o <= v;
        repeat (EMG_MIN_LOW_FC + 1) @(posedge ref_clk_i);
    endtask : set_emg
endmodule : pin_source

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import pulse_timer_pkg::*;
;
    logic ref_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0, strb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, low_power_mode_i = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic trigger_pin_i, emergency_stop_pin_n_i, wave_out_one_o, wave_out_two_o;
    logic trigger_start_irq_o, period_irq_o, emergency_stop_irq_o;
    int n_fail, samples_checked, cyc, last_per, gap, n_trig, n_per, n_emg, e_trig, e_emg, k;
    logic [31:0] rnd = 32'h0000_0500;
    logic [15:0] per;
    always #12.5 ref_clk_i = ~ref_clk_i;
    pulse_timer_unit DUT (.*);
    pin_source SRC (.ref_clk_i(ref_clk_i), .trigger_pin_o(trigger_pin_i),
        .emergency_stop_pin_n_o(emergency_stop_pin_n_i));
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (trigger_start_irq_o === 1'h1) n_trig <= n_trig + 1;
        if (emergency_stop_irq_o === 1'h1) n_emg <= n_emg + 1;
        if (period_irq_o === 1'h1) begin
            n_per <= n_per + 1;
            gap <= cyc - last_per;
            last_per <= cyc;
        end
    end
    // ******
    // Helpers
    // ******
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic results();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    task automatic timeout();
        n_fail++;
        $display("ERROR %0t wait limit reached", $time);
        results();
    endtask : timeout
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'h0;
                chk(s_axi_bresp, RESP_OKAY);
                break;
            end
        end
        if (i == 50) timeout();
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'h0;
                chk(s_axi_rdata, e);
                chk(s_axi_rresp, er);
                break;
            end
        end
        if (i == 50) timeout();
    endtask : rd
    task automatic flag(input logic [7:0] e);
        rd(OFS_CTRL_THREE, {24'h00_0000, e}, RESP_OKAY);
        chk(s_axi_rdata[B_EMG_FLAG], e[B_EMG_FLAG]);
    endtask : flag
    task automatic wait_n(input int w, input int t);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge ref_clk_i);
            if ((w == 0 ? n_trig : (w == 1 ? n_per : n_emg)) >= t) break;
        end
        if (i == 600) timeout();
    endtask : wait_n
    // ******
    // Main sequence
    // ******
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'h1;
        rd(OFS_CTRL_TWO, 32'h0000_0000, RESP_OKAY);
        chk(s_axi_rdata[B_EMG_EN], 1'h0);
        rd(OFS_PERIOD, {16'h0000, PERIOD_RST}, RESP_OKAY);
        rd(8'h18, 32'h0000_0000, RESP_SLVERR);
        rnd = xs(rnd);
        per = 16'h0003 + {13'h0000, rnd[2:0]};
        strb = rnd[7:4];
        wr(OFS_DEAD, 32'hFFFF_FFFF);
        rd(OFS_DEAD, {16'h0000, {8{strb[1]}}, {8{strb[0]}}}, RESP_OKAY);
        strb = 4'hF;
        wr(OFS_PERIOD, {16'h0000, per});
        wr(OFS_CTRL_ONE, 32'h0000_0002);
        wr(OFS_CTRL_THREE, 32'h0000_0001);
        wait_n(1, n_per + 3);
        chk(gap, per + 16'h0001);
        wr(OFS_CTRL_TWO, 32'h0000_0001);
        SRC.set_emg(1'h0);
        e_emg++;
        wait_n(2, e_emg);
        flag(8'h31);
        chk({wave_out_two_o, wave_out_one_o}, 2'h2);
        wait_n(1, n_per + 2);
        chk(gap, per + 16'h0001);
        wr(OFS_CTRL_THREE, 32'h0000_0000);
        wr(OFS_CTRL_THREE, 32'h0000_0001);
        rd(OFS_CTRL_THREE, 32'h0000_0010, RESP_OKAY);
        chk(s_axi_rdata[B_RUN], 1'h0);
        wr(OFS_CTRL_THREE, 32'h0000_0000);
        wr(OFS_CTRL_TWO, 32'h0000_0081);
        e_emg++;
        wait_n(2, e_emg);
        SRC.set_emg(1'h1);
        wr(OFS_CTRL_THREE, 32'h0000_0002);
        wr(OFS_CTRL_TWO, 32'h0000_0081);
        flag(8'h12);
        wr(OFS_CTRL_THREE, 32'h0000_0000);
        wr(OFS_CTRL_TWO, 32'h0000_0081);
        flag(8'h00);
        wr(OFS_CTRL_TWO, 32'h0000_0000);
        SRC.set_emg(1'h0);
        repeat (EMG_RESP_FC) @(posedge ref_clk_i);
        chk(n_emg, e_emg);
        flag(8'h00);
        SRC.set_emg(1'h1);
        wr(OFS_CTRL_ONE, 32'h0000_0006);
        wr(OFS_CTRL_TWO, 32'h0000_0001);
        k = n_per;
        wr(OFS_CTRL_THREE, 32'h0000_0001);
        repeat (20) @(posedge ref_clk_i);
        rd(OFS_CTRL_THREE, 32'h0000_0001, RESP_OKAY);
        chk(n_per, k);
        SRC.set_emg(1'h0);
        e_emg++;
        wait_n(2, e_emg);
        SRC.set_trig(1'h1);
        e_trig++;
        wait_n(0, e_trig);
        chk(n_trig, e_trig);
        wr(OFS_CTRL_THREE, 32'h0000_0000);
        SRC.set_emg(1'h1);
        wr(OFS_CTRL_TWO, 32'h0000_0081);
        wr(OFS_CTRL_ONE, 32'h0000_0016);
        wr(OFS_CTRL_THREE, 32'h0000_0001);
        SRC.set_trig(1'h0);
        SRC.set_trig(1'h1);
        chk(n_trig, e_trig);
        chk(n_emg, e_emg);
        wr(OFS_CTRL_THREE, 32'h0000_0002);
        low_power_mode_i <= 1'h1;
        repeat (4) @(posedge ref_clk_i);
        low_power_mode_i <= 1'h0;
        rd(OFS_CTRL_THREE, 32'h0000_0000, RESP_OKAY);
        chk(s_axi_rdata[B_RUN], 1'h0);
        chk({wave_out_two_o, wave_out_one_o}, 2'h2);
        results();
    end
endmodule : tb_top
